// ===== dao_pkg.sv
// Purpose: Shared constants and types for the dual converter output block.
// Assumes: One system clock; samples arrive as digital words from the analog front end.
// Notes: Register map sits on a plain strobe port.
package dao_pkg;

  localparam int unsigned DAO_RES_W = 12;
  localparam int unsigned DAO_LATENCY = 6;
  localparam int unsigned DAO_CLK_MHZ = 250;
  localparam int unsigned DAO_MIN_RATE_MSPS = 40;
  localparam int unsigned DAO_INT_REF_MV = 2000;
  localparam int unsigned DAO_ADDR_W = 4;

  // ****************************************
  // Register offsets and fields.
  // ****************************************
  localparam logic [3:0] DAO_REG_CTRL = 4'h0;
  localparam logic [3:0] DAO_REG_STAT = 4'h4;
  localparam logic [3:0] DAO_REG_DATA = 4'h8;
  localparam int unsigned DAO_CTRL_OEA_N = 0;
  localparam int unsigned DAO_CTRL_OEB_N = 1;
  localparam int unsigned DAO_CTRL_SLEEP = 2;
  localparam int unsigned DAO_CTRL_FMT = 3;
  localparam int unsigned DAO_CTRL_REF = 4;
  localparam logic [4:0] DAO_CTRL_RST = 5'h03;
  localparam logic [2:0] DAO_FILL_RST = 3'h0;

  typedef struct packed {
    logic [DAO_RES_W-1:0] chan_a;
    logic [DAO_RES_W-1:0] chan_b;
  } dao_pair_t;

endpackage : dao_pkg

// ===== dao_top.sv
// Purpose: Dual 12-bit converter digital side: pipeline, format, output enables, controls.
// Assumes: Raw samples come in offset binary on the sampling edge; capture logic reads both buses.
// Notes: Pins are split into value and enable; the bench checks each one separately.
//
// The address-and-strobe port and the address map are this design's own decisions.
module dao_top
  import dao_pkg::*;
#(
  parameter int unsigned RES_W = DAO_RES_W,
  parameter int unsigned LATENCY = DAO_LATENCY
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Analog front end samples.
  input wire logic [RES_W-1:0] sample_a,
  input wire logic [RES_W-1:0] sample_b,
  // Static control pins.
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  input wire logic sleep_request,
  input wire logic result_format_select,
  input wire logic reference_source_select,
  // Register port.
  input wire logic [DAO_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Result buses.
  output logic [RES_W-1:0] chan_a_result_bus,
  output logic [RES_W-1:0] chan_a_result_oe,
  output logic [RES_W-1:0] chan_b_result_bus,
  output logic [RES_W-1:0] chan_b_result_oe,
  // Stream out of the buffer.
  output logic stream_valid,
  input wire logic stream_ready,
  output dao_pair_t stream_data,
  // Status.
  output logic sleep_active,
  output logic ref_external
);

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_sync;
  logic [4:0] ctrl_r;
  logic [4:0] eff;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_s1_r <= DAO_CTRL_RST;
      pin_s2_r <= DAO_CTRL_RST;
    end
    else
    begin
      pin_s1_r <= {reference_source_select, result_format_select, sleep_request,
                   chan_b_output_enable_n, chan_a_output_enable_n};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign pin_sync = pin_s2_r;
  // Pin level or software control: enables AND (either may float), modes OR.
  assign eff = {pin_sync[4:2] | ctrl_r[4:2], pin_sync[1:0] | ctrl_r[1:0]};

  wire en_a = ~eff[DAO_CTRL_OEA_N];
  wire en_b = ~eff[DAO_CTRL_OEB_N];
  wire sleeping = eff[DAO_CTRL_SLEEP];
  wire fmt_twos = eff[DAO_CTRL_FMT];
  wire ref_ext = eff[DAO_CTRL_REF];

  // ****************************************
  // Sampling pipeline.
  // ****************************************
  logic [RES_W-1:0] pipe_a_r [LATENCY];
  logic [RES_W-1:0] pipe_b_r [LATENCY];

  // Stage 0 catches both channels on the same rising edge; sleep freezes the input.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pipe_a_r[0] <= '0;
      pipe_b_r[0] <= '0;
    end
    else if (!sleeping)
    begin
      pipe_a_r[0] <= sample_a;
      pipe_b_r[0] <= sample_b;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < LATENCY; gi++)
    begin : g_pipe
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          pipe_a_r[gi] <= '0;
          pipe_b_r[gi] <= '0;
        end
        else
        begin
          pipe_a_r[gi] <= pipe_a_r[gi-1];
          pipe_b_r[gi] <= pipe_b_r[gi-1];
        end
      end
    end
  endgenerate

  // Stage LATENCY-1 feeds the output flops, giving seven edges to the bus.
  wire [RES_W-1:0] msb_flip = {1'b1, {(RES_W-1){1'b0}}};
  wire [RES_W-1:0] word_a = fmt_twos ? (pipe_a_r[LATENCY-1] ^ msb_flip) : pipe_a_r[LATENCY-1];
  wire [RES_W-1:0] word_b = fmt_twos ? (pipe_b_r[LATENCY-1] ^ msb_flip) : pipe_b_r[LATENCY-1];

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      chan_a_result_bus <= '0;
      chan_b_result_bus <= '0;
      chan_a_result_oe <= '0;
      chan_b_result_oe <= '0;
      sleep_active <= 1'b0;
      ref_external <= 1'b0;
    end
    else
    begin
      chan_a_result_bus <= word_a;
      chan_b_result_bus <= word_b;
      chan_a_result_oe <= {RES_W{en_a}};
      chan_b_result_oe <= {RES_W{en_b}};
      sleep_active <= sleeping;
      ref_external <= ref_ext;
    end
  end

  // ****************************************
  // Two-entry buffer toward capture logic.
  // ****************************************
  dao_pair_t buf_r [2];
  logic [1:0] cnt_r;
  logic wptr_r;
  logic rptr_r;
  wire pop = stream_valid && stream_ready;
  // A pop in the same cycle frees the head slot, so a full buffer still accepts a word.
  wire push = !sleeping && ((cnt_r != 2'd2) || pop);
  // When the buffer empties into the slot being written, that word goes straight out.
  wire rd_sel = pop ? ~rptr_r : rptr_r;
  wire bypass = push && (cnt_r == {1'b0, pop});
  dao_pair_t in_word;
  assign in_word = '{chan_a: word_a, chan_b: word_b};
  logic [7:0] drop_cnt_r;
  wire drop = !sleeping && (cnt_r == 2'd2) && !pop;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_r <= '0;
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      drop_cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wptr_r] <= in_word;
        wptr_r <= ~wptr_r;
      end
      if (pop)
        rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (drop && drop_cnt_r != 8'hff)
        drop_cnt_r <= drop_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      stream_valid <= 1'b0;
      stream_data <= '0;
    end
    else
    begin
      stream_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'd0;
      stream_data <= bypass ? in_word : buf_r[rd_sel];
    end
  end

  // ****************************************
  // Register port.
  // ****************************************
  wire hit_ctrl = (reg_addr == DAO_REG_CTRL);
  wire hit_stat = (reg_addr == DAO_REG_STAT);
  wire hit_data = (reg_addr == DAO_REG_DATA);
  wire [31:0] stat_word = {16'h0000, drop_cnt_r, 1'b0, cnt_r, eff};
  wire [31:0] data_word = {8'h00, chan_a_result_bus, chan_b_result_bus};
  wire [31:0] rd_mux = hit_ctrl ? {27'h000_0000, ctrl_r} :
                       hit_stat ? stat_word :
                       hit_data ? data_word : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_r <= 5'h00;
      reg_rdata <= '0;
    end
    else
    begin
      if (reg_wr && hit_ctrl)
        ctrl_r <= reg_wdata[4:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  // Eight edges out of reset, awake and in offset binary.
  sequence s_running;
    (!srst && !sleeping && !fmt_twos) [*8];
  endsequence

  property p_latency;
    @(posedge clk_sys) disable iff (srst)
    s_running |-> chan_a_result_bus == $past(sample_a, 7);
  endproperty
  a_latency: assert property (p_latency) else $error("Latency wrong.");

  property p_pair;
    @(posedge clk_sys) disable iff (srst)
    s_running |-> chan_b_result_bus == $past(sample_b, 7);
  endproperty
  a_pair: assert property (p_pair) else $error("Channel B misaligned.");

  property p_oe;
    @(posedge clk_sys) disable iff (srst)
    1'b1 |=> chan_a_result_oe == {RES_W{~$past(eff[DAO_CTRL_OEA_N])}};
  endproperty
  a_oe: assert property (p_oe) else $error("Enable A wrong.");

  property p_oe_b;
    @(posedge clk_sys) disable iff (srst)
    $rose(pin_sync[DAO_CTRL_OEB_N]) |=> chan_b_result_oe == '0;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("Bus B not floated.");

  property p_sleep;
    @(posedge clk_sys) disable iff (srst)
    sleeping [*8] |-> $stable(chan_a_result_bus) || ($past(fmt_twos) != $past(fmt_twos, 2));
  endproperty
  a_sleep: assert property (p_sleep) else $error("Output moved in sleep.");

  property p_fmt;
    @(posedge clk_sys) disable iff (srst)
    $changed(fmt_twos) && !sleeping |=>
      chan_a_result_bus == ($past(pipe_a_r[LATENCY-1]) ^ {$past(fmt_twos), {(RES_W-1){1'b0}}});
  endproperty
  a_fmt: assert property (p_fmt) else $error("Format flip wrong.");

  property p_ref;
    @(posedge clk_sys) disable iff (srst)
    ref_ext |=> ref_external;
  endproperty
  a_ref: assert property (p_ref) else $error("Reference select lost.");

  property p_rate;
    @(posedge clk_sys) disable iff (srst)
    s_running ##1 (!srst && !sleeping && !fmt_twos) |->
      $changed(chan_a_result_bus) == ($past(sample_a, 7) != $past(sample_a, 8));
  endproperty
  a_rate: assert property (p_rate) else $error("Result not updated.");

  property p_hold;
    @(posedge clk_sys) disable iff (srst)
    stream_valid && !stream_ready |=> stream_valid && $stable(stream_data);
  endproperty
  a_hold: assert property (p_hold) else $error("Stream word moved while stalled.");

  property p_buf;
    @(posedge clk_sys) disable iff (srst)
    cnt_r <= 2'd2;
  endproperty
  a_buf: assert property (p_buf) else $error("Buffer overfilled.");

endmodule : dao_top

// ===== dao_capture_model.sv
// Purpose: Capture logic model on the stream side of the converter block.
// Assumes: One clock shared with the block; bench drives complementary samples.
// Notes: Stall holds ready low so that the buffer fills.
module dao_capture_model
  import dao_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Control from the bench.
  input wire logic stall,
  // Stream from the block.
  input wire logic stream_valid,
  output logic stream_ready,
  input wire dao_pair_t stream_data,
  // Tallies.
  output logic [15:0] taken_cnt,
  output logic [15:0] pair_err_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Accepts words and checks that each pair after the first seventeen shares one instant.
  // ****
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      stream_ready <= 1'b0;
      taken_cnt <= 16'h0000;
      pair_err_cnt <= 16'h0000;
    end
    else
    begin
      stream_ready <= ~stall;
      if (stream_valid && stream_ready)
      begin
        taken_cnt <= taken_cnt + 16'h0001;
        if (taken_cnt > 16'h0010 && stream_data.chan_b !== ~stream_data.chan_a)
        begin
          pair_err_cnt <= pair_err_cnt + 16'h0001;
        end
      end
    end
  end
endmodule : dao_capture_model

// ===== dao_top_tb.sv
// Purpose: Self-checking bench for the dual converter output block.
// Assumes: Channel B samples are always the complement of channel A.
// Notes: A word driven at one edge is on the bus seven bench cycles later.
module dao_top_tb
  import dao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [11:0] sample_a = 12'h000;
  logic [11:0] sample_b = 12'hfff;
  logic [4:0] pins = 5'h00;
  logic [DAO_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] chan_a_result_bus, chan_a_result_oe, chan_b_result_bus, chan_b_result_oe;
  logic stream_valid, stream_ready, sleep_active, ref_external, stall = 1'b0;
  dao_pair_t stream_data;
  logic [15:0] taken_cnt, pair_err_cnt;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] cyc = 8'h00;
  logic [11:0] hist [256];
  logic chk_en = 1'b0;
  logic fmt_exp = 1'b0;
  logic [11:0] exp_a, exp_b, held;
  logic [31:0] rd;
  dao_top u_dut (.clk_sys(clk_sys), .srst(srst), .sample_a(sample_a), .sample_b(sample_b),
    .chan_a_output_enable_n(pins[DAO_CTRL_OEA_N]), .chan_b_output_enable_n(pins[DAO_CTRL_OEB_N]),
    .sleep_request(pins[DAO_CTRL_SLEEP]), .result_format_select(pins[DAO_CTRL_FMT]),
    .reference_source_select(pins[DAO_CTRL_REF]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_a_result_bus(chan_a_result_bus), .chan_a_result_oe(chan_a_result_oe),
    .chan_b_result_bus(chan_b_result_bus), .chan_b_result_oe(chan_b_result_oe),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data),
    .sleep_active(sleep_active), .ref_external(ref_external));
  dao_capture_model u_cap (.clk_sys(clk_sys), .srst(srst), .stall(stall),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data),
    .taken_cnt(taken_cnt), .pair_err_cnt(pair_err_cnt));
  // ****
  // Clock, samples and the running result check.
  // ****
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 8'h01;
    sample_a <= {cyc[3:0], cyc} ^ 12'h5a3;
    sample_b <= ~({cyc[3:0], cyc} ^ 12'h5a3);
    hist[cyc] <= {cyc[3:0], cyc} ^ 12'h5a3;
  end
  always @(negedge clk_sys)
  begin
    if (chk_en)
    begin
      exp_a = hist[cyc - 8'h08];
      exp_a[11] = exp_a[11] ^ fmt_exp;
      exp_b = ~exp_a;
      check(chan_a_result_bus, exp_a);
      check(chan_b_result_bus, exp_b);
    end
  end
  // ****
  // Tasks.
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cyc
  task automatic set_pins(input logic [4:0] p);
    @(posedge clk_sys);
    pins <= p;
  endtask : set_pins
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_read
  task automatic run_chk();
    wait_cyc(12);
    chk_en = 1'b1;
    wait_cyc(20);
    chk_en = 1'b0;
  endtask : run_chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ****
  // Test sequence.
  // ****
  initial
  begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    reg_read(4'h0, rd);
    check(rd, 32'h0000_0000);
    check(chan_a_result_oe, 12'h000);
    reg_read(4'hc, rd);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    reg_write(4'h0, 32'h0000_0000);
    wait_cyc(6);
    check(chan_a_result_oe, 12'hfff);
    check(chan_b_result_oe, 12'hfff);
    run_chk();
    $display("test latency done");
    fmt_exp = 1'b1;
    set_pins(5'h08);
    run_chk();
    set_pins(5'h00);
    reg_write(4'h0, 32'h0000_0008);
    run_chk();
    reg_write(4'h0, 32'h0000_0000);
    fmt_exp = 1'b0;
    set_pins(5'h02);
    wait_cyc(6);
    check(chan_b_result_oe, 12'h000);
    check(chan_a_result_oe, 12'hfff);
    $display("test format and enables done");
    set_pins(5'h10);
    wait_cyc(6);
    check(ref_external, 1'b1);
    reg_read(4'h4, rd);
    check(rd & 32'h0000_001f, 32'h0000_0010);
    set_pins(5'h00);
    reg_write(4'h0, 32'h0000_0010);
    wait_cyc(6);
    check(ref_external, 1'b1);
    reg_write(4'h0, 32'h0000_0000);
    wait_cyc(6);
    check(ref_external, 1'b0);
    $display("test reference done");
    @(posedge clk_sys);
    stall <= 1'b1;
    wait_cyc(8);
    reg_read(4'h4, rd);
    check(rd[6:5], 2'h2);
    check(rd[15:8] != 8'h00, 1'b1);
    set_pins(5'h04);
    stall <= 1'b0;
    wait_cyc(10);
    check(sleep_active, 1'b1);
    check(stream_valid, 1'b0);
    held = chan_a_result_bus;
    reg_read(4'h4, rd);
    check(rd & 32'h0000_007f, 32'h0000_0004);
    check(chan_a_result_bus, held);
    set_pins(5'h00);
    wait_cyc(6);
    check(sleep_active, 1'b0);
    run_chk();
    check(pair_err_cnt, 16'h0000);
    check(taken_cnt != 16'h0000, 1'b1);
    $display("test sleep and buffer done");
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
endmodule : dao_top_tb
